//--- dpg_map.svh
`ifndef DPG_MAP_SVH
`define DPG_MAP_SVH

// Register byte offsets on the APB slave.
`define DPG_OFS_CTRL     12'h000
`define DPG_OFS_WIDTH    12'h004
`define DPG_OFS_RISE     12'h008
`define DPG_OFS_FALL     12'h00c
`define DPG_OFS_SPACING  12'h010
`define DPG_OFS_PERIOD   12'h014
`define DPG_OFS_STATUS   12'h018
`define DPG_OFS_FREQ     12'h01c
`define DPG_OFS_LEVEL    12'h020
`define DPG_OFS_MODE     12'h024

// Control register bit positions.
`define DPG_CTRL_EXT      0
`define DPG_CTRL_BYPASS   1
`define DPG_CTRL_CARRIER  2
`define DPG_CTRL_RESTORE  3

// Status register bit positions.
`define DPG_STAT_ILLEGAL  0
`define DPG_STAT_WARN     1
`define DPG_STAT_BUSY     2
`define DPG_STAT_SYNC     3

// Mode codes; the pulse-pair code value is arbitrary.
`define DPG_MODE_OFF     2'h0
`define DPG_MODE_PAIR    2'h1

// Timing: settings are held in steps of the resolution.
`define DPG_CLK_NS       10
`define DPG_RES_NS       50
`define DPG_UNIT_CYC     (`DPG_RES_NS / `DPG_CLK_NS)
`define DPG_SYNC_NS      400
`define DPG_SYNC_CYC     6'((`DPG_SYNC_NS) / `DPG_CLK_NS)
`define DPG_RATE_PPS     6000
`define DPG_PERIOD_DEF   21'(1000000000 / (`DPG_RATE_PPS * `DPG_RES_NS))

// Setting limits and defaults, in resolution steps.
`define DPG_WIDTH_MIN    10'h032
`define DPG_WIDTH_MAX    10'h0a0
`define DPG_WIDTH_DEF    10'h046
`define DPG_RISE_MIN     10'h010
`define DPG_RISE_MAX     10'h073
`define DPG_RISE_DEF     10'h01c
`define DPG_FALL_MIN     10'h01e
`define DPG_FALL_MAX     10'h073
`define DPG_FALL_DEF     10'h01e
`define DPG_SPC_MIN      10'h0b4
`define DPG_SPC_MAX      10'h384
`define DPG_SPC_DEF      10'h0f0
`define DPG_PERIOD_MIN   21'h000d05
`define DPG_PERIOD_MAX   21'h1e8480

// Carrier defaults: MHz, and tenths of a dB as two's complement.
`define DPG_FREQ_DEF     11'h401
`define DPG_LEVEL_DEF    16'hfbb4

// Amplitude is quantised to this full-scale code.
`define DPG_AMP_MAX      6'h3f

`endif

//--- dpg_pkg.sv
package dpg_pkg;

    typedef enum logic [2:0] {
        DPG_PH_IDLE = 3'b000,
        DPG_PH_RISE = 3'b001,
        DPG_PH_TOP  = 3'b010,
        DPG_PH_FALL = 3'b011,
        DPG_PH_GAP  = 3'b100
    } dpg_phase_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dpg_apb_req_t;

    typedef struct packed {
        logic        trig_meta;
        logic        trig_sync;
        logic        trig_prev;
        logic        ext_mode;
        logic        mod_bypass;
        logic        carrier_on;
        logic [1:0]  mode;
        logic [9:0]  width;
        logic [9:0]  rise;
        logic [9:0]  fall;
        logic [9:0]  spacing;
        logic [20:0] period;
        logic [10:0] freq;
        logic [15:0] level;
        logic [13:0] rise_cyc;
        logic [13:0] fall_cyc;
        logic [13:0] top_cyc;
        logic [13:0] spc_cyc;
        dpg_phase_t  phase;
        logic        second;
        logic [13:0] ph_cnt;
        logic [10:0] acc;
        logic [5:0]  amp;
        logic [13:0] spc_cnt;
        logic [23:0] per_cnt;
        logic [5:0]  sync_cnt;
        logic        sync;
        logic [5:0]  video;
        logic [5:0]  mod_level;
    } dpg_state_t;

endpackage

//--- dpg_pulse_pair.sv
// What this block does
// - Emit shaped pulses in pairs, sync each pair.
// - Sync pulse is 400 ns wide.
// - Accept width 2.50 to 8.00 us.
// - Rise 0.80-5.75 us, fall 1.50-5.75 us.
// - Accept pair spacing 9.00 to 45.00 us.
// - Hold all timings in 0.05 us steps.
// - Edges 10-90 percent, width at half amplitude; each edge here ramps 0-100 percent over its setting.
// - Quantised shape; one step times the sync.
// - Illegal profile blanks video and sync outputs.
// - Outputs return once the profile is legal.
// - Legal non-gaussian shape raises a warning only.
// - Restore recomputes edges from width, re-enables outputs.
// - Internal and external modes, all settings adjustable.
// - Trigger-mode control selects pulse source.
// - External mode starts from external trigger pulse.
// - Modulator drive aligned with video output.
// - Bypass passes carrier; carrier toggle kills RF.
// - Entering mode loads 1025 MHz, -110 dBm.
// - Mode command selects; query reports active mode.
// - Internal defaults 6000 pairs/s, 12 us spacing.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "dpg_map.svh"

module dpg_pulse_pair (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire dpg_pkg::dpg_apb_req_t apb_in,
    output logic [31:0]               prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    input  wire logic                 trig_in,
    output logic [5:0]                video_out,
    output logic                      sync_out,
    output logic [5:0]                mod_level_out,
    output logic                      rf_on_out,
    output logic [10:0]               freq_out,
    output logic [15:0]               level_out
);
    import dpg_pkg::*;

    dpg_state_t  st_q;
    dpg_state_t  st_d;
    logic        illegal;
    logic        warn;
    logic        trig_rise;
    logic        start;
    logic        wr_en;
    logic        addr_ok;
    logic [9:0]  gauss_w;
    logic [9:0]  rise_g;
    logic [9:0]  fall_g;
    logic [10:0] acc_n;
    logic [10:0] edge_sum;

    function automatic logic [9:0] clamp10(input logic [31:0] v,
                                           input logic [9:0]  lo,
                                           input logic [9:0]  hi);
        logic [9:0] r;
        if (v < 32'(lo)) begin
            r = lo;
        end else if (v > 32'(hi)) begin
            r = hi;
        end else begin
            r = v[9:0];
        end
        return r;
    endfunction

    // ****************************************************************
    // Profile checks
    // ****************************************************************

    assign edge_sum = 11'(st_q.rise) + 11'(st_q.fall);
    assign illegal  = (11'(st_q.width) < edge_sum)
                    || ((11'(st_q.width) + edge_sum) > 11'(st_q.spacing));
    // Gaussian edge time is taken as two fifths of the width, then lifted
    // to each edge's floor; this keeps the restored profile legal.
    assign gauss_w  = 10'((32'(st_q.width) * 2) / 5);
    assign rise_g   = (gauss_w < `DPG_RISE_MIN) ? `DPG_RISE_MIN : gauss_w;
    assign fall_g   = (gauss_w < `DPG_FALL_MIN) ? `DPG_FALL_MIN : gauss_w;
    assign warn     = !illegal && ((st_q.rise != rise_g) || (st_q.fall != fall_g));

    assign trig_rise = st_q.trig_sync && !st_q.trig_prev;

    assign start = (st_q.mode == `DPG_MODE_PAIR) && !illegal
                 && (st_q.phase == DPG_PH_IDLE)
                 && (st_q.ext_mode ? trig_rise : (st_q.per_cnt == 24'h000000));

    assign wr_en = apb_in.psel && apb_in.penable && apb_in.pwrite && addr_ok;

    // ****************************************************************
    // APB read decode
    // ****************************************************************

    always_comb begin
        prdata_out = 32'h0;
        addr_ok    = 1'b1;
        if (apb_in.paddr == `DPG_OFS_CTRL) begin
            prdata_out[`DPG_CTRL_EXT]     = st_q.ext_mode;
            prdata_out[`DPG_CTRL_BYPASS]  = st_q.mod_bypass;
            prdata_out[`DPG_CTRL_CARRIER] = st_q.carrier_on;
        end else if (apb_in.paddr == `DPG_OFS_WIDTH) begin
            prdata_out[9:0] = st_q.width;
        end else if (apb_in.paddr == `DPG_OFS_RISE) begin
            prdata_out[9:0] = st_q.rise;
        end else if (apb_in.paddr == `DPG_OFS_FALL) begin
            prdata_out[9:0] = st_q.fall;
        end else if (apb_in.paddr == `DPG_OFS_SPACING) begin
            prdata_out[9:0] = st_q.spacing;
        end else if (apb_in.paddr == `DPG_OFS_PERIOD) begin
            prdata_out[20:0] = st_q.period;
        end else if (apb_in.paddr == `DPG_OFS_STATUS) begin
            prdata_out[`DPG_STAT_ILLEGAL] = illegal;
            prdata_out[`DPG_STAT_WARN]    = warn;
            prdata_out[`DPG_STAT_BUSY]    = st_q.phase != DPG_PH_IDLE;
            prdata_out[`DPG_STAT_SYNC]    = st_q.sync;
        end else if (apb_in.paddr == `DPG_OFS_FREQ) begin
            prdata_out[10:0] = st_q.freq;
        end else if (apb_in.paddr == `DPG_OFS_LEVEL) begin
            prdata_out[15:0] = st_q.level;
        end else if (apb_in.paddr == `DPG_OFS_MODE) begin
            prdata_out[1:0] = st_q.mode;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // The slave never stretches a transfer, so reads come straight off state.
    assign pready_out  = 1'b1;
    assign pslverr_out = apb_in.psel && apb_in.penable && !addr_ok;

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        st_d = st_q;
        acc_n = 11'h000;
        st_d.trig_meta = trig_in;
        st_d.trig_sync = st_q.trig_meta;
        st_d.trig_prev = st_q.trig_sync;

        // Register writes.
        if (wr_en) begin
            if (apb_in.paddr == `DPG_OFS_CTRL) begin
                st_d.ext_mode   = apb_in.pwdata[`DPG_CTRL_EXT];
                st_d.mod_bypass = apb_in.pwdata[`DPG_CTRL_BYPASS];
                st_d.carrier_on = apb_in.pwdata[`DPG_CTRL_CARRIER];
                if (apb_in.pwdata[`DPG_CTRL_RESTORE]) begin
                    st_d.rise = rise_g;
                    st_d.fall = fall_g;
                    st_d.spacing = clamp10(32'(st_q.width) + 32'(rise_g) + 32'(fall_g),
                                           st_q.spacing, `DPG_SPC_MAX);
                end
            end else if (apb_in.paddr == `DPG_OFS_WIDTH) begin
                st_d.width = clamp10(apb_in.pwdata, `DPG_WIDTH_MIN, `DPG_WIDTH_MAX);
            end else if (apb_in.paddr == `DPG_OFS_RISE) begin
                st_d.rise = clamp10(apb_in.pwdata, `DPG_RISE_MIN, `DPG_RISE_MAX);
            end else if (apb_in.paddr == `DPG_OFS_FALL) begin
                st_d.fall = clamp10(apb_in.pwdata, `DPG_FALL_MIN, `DPG_FALL_MAX);
            end else if (apb_in.paddr == `DPG_OFS_SPACING) begin
                st_d.spacing = clamp10(apb_in.pwdata, `DPG_SPC_MIN, `DPG_SPC_MAX);
            end else if (apb_in.paddr == `DPG_OFS_PERIOD) begin
                if (apb_in.pwdata < 32'(`DPG_PERIOD_MIN)) begin
                    st_d.period = `DPG_PERIOD_MIN;
                end else if (apb_in.pwdata > 32'(`DPG_PERIOD_MAX)) begin
                    st_d.period = `DPG_PERIOD_MAX;
                end else begin
                    st_d.period = apb_in.pwdata[20:0];
                end
            end else if (apb_in.paddr == `DPG_OFS_FREQ) begin
                st_d.freq = apb_in.pwdata[10:0];
            end else if (apb_in.paddr == `DPG_OFS_LEVEL) begin
                st_d.level = apb_in.pwdata[15:0];
            end else if (apb_in.paddr == `DPG_OFS_MODE) begin
                st_d.mode = apb_in.pwdata[1:0];
                if (apb_in.pwdata[1:0] == `DPG_MODE_PAIR && st_q.mode != `DPG_MODE_PAIR) begin
                    st_d.freq  = `DPG_FREQ_DEF;
                    st_d.level = `DPG_LEVEL_DEF;
                end
            end
        end

        if (st_q.ext_mode) begin
            st_d.per_cnt = 24'h000000;
        end else if (st_q.per_cnt == 24'h000000) begin
            st_d.per_cnt = 24'(32'(st_q.period) * `DPG_UNIT_CYC - 1);
        end else begin
            st_d.per_cnt = st_q.per_cnt - 24'h000001;
        end

        if (st_q.phase != DPG_PH_IDLE) begin
            st_d.spc_cnt = st_q.spc_cnt + 14'h0001;
        end

        case (st_q.phase)
            DPG_PH_IDLE: begin
                if (start) begin
                    st_d.rise_cyc = 14'(32'(st_q.rise) * `DPG_UNIT_CYC);
                    st_d.fall_cyc = 14'(32'(st_q.fall) * `DPG_UNIT_CYC);
                    st_d.spc_cyc  = 14'(32'(st_q.spacing) * `DPG_UNIT_CYC);
                    st_d.top_cyc  = 14'(32'(st_q.width) * `DPG_UNIT_CYC
                                  - (32'(st_q.rise) + 32'(st_q.fall)) * `DPG_UNIT_CYC / 2);
                    st_d.phase   = DPG_PH_RISE;
                    st_d.second  = 1'b0;
                    st_d.ph_cnt  = 14'h0000;
                    st_d.acc     = 11'h000;
                    st_d.amp     = 6'h00;
                    st_d.spc_cnt = 14'h0000;
                end
            end
            DPG_PH_RISE: begin
                acc_n = st_q.acc + 11'(`DPG_AMP_MAX);
                if (acc_n >= 11'(st_q.rise_cyc)) begin
                    st_d.acc = acc_n - 11'(st_q.rise_cyc);
                    st_d.amp = (st_q.amp == `DPG_AMP_MAX) ? st_q.amp : st_q.amp + 6'h01;
                end else begin
                    st_d.acc = acc_n;
                end
                st_d.ph_cnt = st_q.ph_cnt + 14'h0001;
                if (st_q.ph_cnt == st_q.rise_cyc - 14'h0001) begin
                    st_d.amp    = `DPG_AMP_MAX;
                    st_d.ph_cnt = 14'h0000;
                    st_d.acc    = 11'h000;
                    st_d.phase  = (st_q.top_cyc == 14'h0000) ? DPG_PH_FALL : DPG_PH_TOP;
                end
            end
            DPG_PH_TOP: begin
                st_d.ph_cnt = st_q.ph_cnt + 14'h0001;
                if (st_q.ph_cnt == st_q.top_cyc - 14'h0001) begin
                    st_d.ph_cnt = 14'h0000;
                    st_d.phase  = DPG_PH_FALL;
                end
            end
            DPG_PH_FALL: begin
                acc_n = st_q.acc + 11'(`DPG_AMP_MAX);
                if (acc_n >= 11'(st_q.fall_cyc)) begin
                    st_d.acc = acc_n - 11'(st_q.fall_cyc);
                    st_d.amp = (st_q.amp == 6'h00) ? st_q.amp : st_q.amp - 6'h01;
                end else begin
                    st_d.acc = acc_n;
                end
                st_d.ph_cnt = st_q.ph_cnt + 14'h0001;
                if (st_q.ph_cnt == st_q.fall_cyc - 14'h0001) begin
                    st_d.amp    = 6'h00;
                    st_d.ph_cnt = 14'h0000;
                    st_d.acc    = 11'h000;
                    st_d.phase  = st_q.second ? DPG_PH_IDLE : DPG_PH_GAP;
                end
            end
            DPG_PH_GAP: begin
                if (st_q.spc_cnt == st_q.spc_cyc - 14'h0001) begin
                    st_d.phase  = DPG_PH_RISE;
                    st_d.second = 1'b1;
                    st_d.ph_cnt = 14'h0000;
                    st_d.acc    = 11'h000;
                end
            end
            default: begin
                st_d.phase = DPG_PH_IDLE;
            end
        endcase

        // abort while illegal, resume when legal
        if (illegal || st_q.mode != `DPG_MODE_PAIR) begin
            st_d.phase = DPG_PH_IDLE;
            st_d.amp   = 6'h00;
        end

        // sync timed by first step off minimum
        if (st_q.phase == DPG_PH_RISE && !st_q.second
            && st_q.amp == 6'h00 && st_d.amp != 6'h00) begin
            st_d.sync_cnt = `DPG_SYNC_CYC;
        end else if (st_q.sync_cnt != 6'h00) begin
            st_d.sync_cnt = st_q.sync_cnt - 6'h01;
        end

        st_d.sync  = (st_d.sync_cnt != 6'h00) && !illegal;
        st_d.video = illegal ? 6'h00 : st_d.amp;
        if (!st_q.carrier_on) begin
            st_d.mod_level = 6'h00;
        end else if (st_q.mod_bypass) begin
            st_d.mod_level = `DPG_AMP_MAX;
        end else begin
            st_d.mod_level = st_d.video;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q            <= '0;
            st_q.carrier_on <= 1'b1;
            st_q.mode       <= `DPG_MODE_PAIR;
            st_q.width      <= `DPG_WIDTH_DEF;
            st_q.rise       <= `DPG_RISE_DEF;
            st_q.fall       <= `DPG_FALL_DEF;
            st_q.spacing    <= `DPG_SPC_DEF;
            st_q.period     <= `DPG_PERIOD_DEF;
            st_q.freq       <= `DPG_FREQ_DEF;
            st_q.level      <= `DPG_LEVEL_DEF;
            st_q.phase      <= DPG_PH_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign video_out     = st_q.video;
    assign sync_out      = st_q.sync;
    assign mod_level_out = st_q.mod_level;
    assign rf_on_out     = st_q.carrier_on;
    assign freq_out      = st_q.freq;
    assign level_out     = st_q.level;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_sync_fixed_width: assert property (
        $rose(sync_out) |-> (sync_out throughout ##39 1'b1) ##1 !sync_out)
        else $error("sync pulse width is not 40 cycles");
    a_blank_on_illegal: assert property (
        illegal |=> (video_out == 6'h00) && !sync_out)
        else $error("outputs not blanked for illegal profile");
    a_width_in_range: assert property (
        st_q.width >= `DPG_WIDTH_MIN && st_q.width <= `DPG_WIDTH_MAX)
        else $error("width setting out of range");
    a_spacing_in_range: assert property (
        st_q.spacing >= `DPG_SPC_MIN && st_q.spacing <= `DPG_SPC_MAX)
        else $error("spacing setting out of range");
    a_restore_legal: assert property (
        wr_en && apb_in.paddr == `DPG_OFS_CTRL && apb_in.pwdata[`DPG_CTRL_RESTORE]
        |=> !illegal && !warn)
        else $error("restore did not yield a legal gaussian profile");
    a_ext_edge_start: assert property (
        st_q.ext_mode && trig_rise && st_q.phase == DPG_PH_IDLE && !illegal
        && st_q.mode == `DPG_MODE_PAIR |=> st_q.phase == DPG_PH_RISE ##[2:10] sync_out)
        else $error("trigger edge did not start a pair with sync");
    a_entry_defaults: assert property (
        wr_en && apb_in.paddr == `DPG_OFS_MODE && apb_in.pwdata[1:0] == `DPG_MODE_PAIR
        && st_q.mode != `DPG_MODE_PAIR |=> freq_out == `DPG_FREQ_DEF
        && level_out == `DPG_LEVEL_DEF)
        else $error("carrier defaults not loaded on mode entry");
    a_bypass_carrier: assert property (
        ##1 (mod_level_out == (!$past(st_q.carrier_on) ? 6'h00
            : $past(st_q.mod_bypass) ? `DPG_AMP_MAX : video_out)))
        else $error("modulator drive does not follow controls");
    a_unmapped_error: assert property (
        apb_in.psel && apb_in.penable && !addr_ok |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not flagged");

    c_internal_pair: cover property (
        !st_q.ext_mode && $rose(st_q.second));
    c_external_pair: cover property (st_q.ext_mode && $rose(sync_out));
    c_illegal_recover: cover property ($fell(illegal) ##[1:1000] $rose(sync_out));
    c_restore_used: cover property (
        wr_en && apb_in.paddr == `DPG_OFS_CTRL && apb_in.pwdata[`DPG_CTRL_RESTORE] && illegal);

endmodule

`default_nettype wire

//--- dpg_trig_src.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// External trigger source
// ****************************************************************
module dpg_trig_src (
    input  wire logic clk_in,
    input  wire logic fire_in,
    output var logic  trig_out
);
    int hold_cnt = 0;

    initial trig_out = 1'b0;

    // pulsed trigger level
    // A pulse of 20 cycles is far longer than the two-flop synchroniser needs.
    always @(posedge clk_in) begin
        if (fire_in) begin
            hold_cnt <= 20;
            trig_out <= 1'b1;
        end else if (hold_cnt > 1) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            hold_cnt <= 0;
            trig_out <= 1'b0;
        end
    end
endmodule

`default_nettype wire

//--- tb_dme_pulse_pair_generator.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpg_map.svh"

module tb_dme_pulse_pair_generator;
    import dpg_pkg::*;
    logic         clk_in, rst_n_in, trig_in, fire, sync_out, pready_out, pslverr_out;
    logic         rf_on_out, sync_d, err;
    dpg_apb_req_t apb;
    logic [31:0]  prdata_out, rdat;
    logic [5:0]   video_out, mod_level_out, video_d;
    logic [10:0]  freq_out;
    logic [15:0]  level_out;
    int           n_errors, checks, n_sync, sync_len, cyc, s0;
    int           starts[$];
    localparam logic [11:0] CA[6] = '{`DPG_OFS_WIDTH, `DPG_OFS_WIDTH, `DPG_OFS_RISE,
                                      `DPG_OFS_FALL, `DPG_OFS_SPACING, `DPG_OFS_SPACING};
    localparam logic [31:0] CW[6] = '{32'h0, 32'h3ff, 32'h0, 32'h3ff, 32'h0, 32'h3ff};
    localparam logic [31:0] CE[6] = '{32'h32, 32'ha0, 32'h10, 32'h73, 32'hb4, 32'h384};

    dpg_pulse_pair dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(apb),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .trig_in(trig_in), .video_out(video_out), .sync_out(sync_out),
        .mod_level_out(mod_level_out), .rf_on_out(rf_on_out), .freq_out(freq_out),
        .level_out(level_out));
    dpg_trig_src src (.clk_in(clk_in), .fire_in(fire), .trig_out(trig_in));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task summarize();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Bus and trigger tasks
    // ****************************************************************
    task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        apb.penable <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        rdat = prdata_out;
        err = pslverr_out;
        apb <= '0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        apb_xfer(1'b0, a, 32'h0);
        chk(n, rdat & m, e);
    endtask

    task shoot(input int gap);
        @(posedge clk_in);
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
        repeat (gap) @(posedge clk_in);
    endtask

    // Sync pulses are measured and counted here, outside the test sequence.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        sync_d <= sync_out;
        video_d <= video_out;
        if (sync_out === 1'b1) sync_len <= sync_len + 1;
        if (sync_out === 1'b1 && sync_d !== 1'b1) begin
            n_sync <= n_sync + 1;
            chk("mod_align", mod_level_out, video_out);
        end
        if (sync_out !== 1'b1 && sync_d === 1'b1) begin
            chk("sync_width", sync_len, 40);
            sync_len <= 0;
        end
        if (video_out !== 6'h00 && video_d === 6'h00) starts.push_back(cyc);
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        n_errors++;
        summarize();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        apb = '0;
        fire = 1'b0;
        rst_n_in = 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 3000 && starts.size() < 2; i++) @(posedge clk_in);
        chk("pulse_count", starts.size(), 2);
        if (starts.size() == 2) chk("pair_spacing", starts[1] - starts[0], 1200);
        chk("sync_per_pair", n_sync, 1);
        rd(`DPG_OFS_WIDTH, 32'hffffffff, 32'h46, "width_def");
        rd(`DPG_OFS_RISE, 32'hffffffff, 32'h1c, "rise_def");
        rd(`DPG_OFS_FALL, 32'hffffffff, 32'h1e, "fall_def");
        rd(`DPG_OFS_SPACING, 32'hffffffff, 32'hf0, "spacing_def");
        rd(`DPG_OFS_PERIOD, 32'hffffffff, 32'hd05, "period_def");
        rd(`DPG_OFS_FREQ, 32'hffffffff, 32'h401, "freq_def");
        rd(`DPG_OFS_LEVEL, 32'hffffffff, 32'hfbb4, "level_def");
        chk("level_pin", level_out, 16'hfbb4);
        chk("freq_pin", freq_out, 11'h401);
        apb_xfer(1'b0, 12'h040, 32'h0);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_data", rdat, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb_xfer(1'b1, CA[i], CW[i]);
            rd(CA[i], 32'hffffffff, CE[i], "clamp");
        end
        apb_xfer(1'b1, `DPG_OFS_WIDTH, 32'h46);
        apb_xfer(1'b1, `DPG_OFS_RISE, 32'h1c);
        apb_xfer(1'b1, `DPG_OFS_FALL, 32'h1e);
        apb_xfer(1'b1, `DPG_OFS_SPACING, 32'hf0);
        apb_xfer(1'b1, `DPG_OFS_CTRL, 32'h5);
        repeat (2000) @(posedge clk_in);
        s0 = n_sync;
        shoot(2000);
        chk("ext_one_pair", n_sync, s0 + 1);
        shoot(2000);
        chk("ext_second_pair", n_sync, s0 + 2);
        apb_xfer(1'b1, `DPG_OFS_RISE, 32'h73);
        rd(`DPG_OFS_STATUS, 32'h1, 32'h1, "illegal_flag");
        shoot(2000);
        chk("blanked", n_sync, s0 + 2);
        apb_xfer(1'b1, `DPG_OFS_CTRL, 32'hd);
        rd(`DPG_OFS_RISE, 32'hffffffff, 32'h1c, "restored_rise");
        rd(`DPG_OFS_STATUS, 32'h3, 32'h0, "restored_ok");
        shoot(2000);
        chk("reenabled", n_sync, s0 + 3);
        apb_xfer(1'b1, `DPG_OFS_RISE, 32'h14);
        rd(`DPG_OFS_STATUS, 32'h3, 32'h2, "warn_flag");
        shoot(2000);
        chk("warn_runs", n_sync, s0 + 4);
        apb_xfer(1'b1, `DPG_OFS_CTRL, 32'h7);
        repeat (3) @(posedge clk_in);
        chk("bypass", mod_level_out, 6'h3f);
        // Stay in external mode so no free-running pair starts with the carrier off.
        apb_xfer(1'b1, `DPG_OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk_in);
        chk("rf_off", rf_on_out, 1'b0);
        chk("mod_off", mod_level_out, 6'h00);
        apb_xfer(1'b1, `DPG_OFS_FREQ, 32'h3c0);
        apb_xfer(1'b1, `DPG_OFS_MODE, 32'h0);
        rd(`DPG_OFS_MODE, 32'hffffffff, 32'h0, "mode_off");
        apb_xfer(1'b1, `DPG_OFS_MODE, 32'h1);
        rd(`DPG_OFS_MODE, 32'hffffffff, 32'h1, "mode_pair");
        chk("freq_entry", freq_out, 11'h401);
        summarize();
    end
endmodule

`default_nettype wire
